/* File: src/blm_board_interrupt_level_mapper.v */
// Notes on behaviour
// - seventeen sources: 7 backplane, 9 local, NMI
// - local: powerfail, sysfail, parity, mailbox, modules, timer, ports
// - powerfail, sysfail, mailbox acknowledged on board only
// - local requests frozen during acknowledge cycle
// - powerfail, sysfail, front panel raise level 7
// - level 7 order: panel, powerfail, parity, sysfail
// - panel autovectored; errors get encoded cause vector
// - default levels mailbox..serial are 6 down to 1
// - mapped levels set by user configuration
// - mailbox autovectored; others get acknowledge strobes
// - autovector option silences that source's strobe
// - two local requests may share one level
// - active-low level outputs; local beats backplane
// - strobe when requesting and address matches level
// - two error vector bits encode the cause
`timescale 1ns/100ps
`default_nettype none
`include "blm_defs.vh"
module blm_board_interrupt_level_mapper #(
	parameter [2:0] LEVEL_MAILBOX = `BLM_LVL_MAILBOX,
	parameter [2:0] LEVEL_MODULE0 = `BLM_LVL_MODULE0,
	parameter [2:0] LEVEL_MODULE1 = `BLM_LVL_MODULE1,
	parameter [2:0] LEVEL_TIMER = `BLM_LVL_TIMER,
	parameter [2:0] LEVEL_PARALLEL = `BLM_LVL_PARALLEL,
	parameter [2:0] LEVEL_SERIAL = `BLM_LVL_SERIAL,
	parameter [5:0] AUTOVECTOR_SELECT = `BLM_AUTO_DEFAULT
) (
	input wire clock,
	input wire rst_n,
	input wire [7:1] backplaneRequest_n,
	input wire powerFailRequest_n,
	input wire systemFailRequest_n,
	input wire boardFail,
	input wire parity_error_request_n,
	input wire mailbox_request_n,
	input wire module0_request_n,
	input wire module1_request_n,
	input wire timer_request_n,
	input wire parallel_port_request_n,
	input wire serial_port_request_n,
	input wire front_panel_nmi_input_n,
	input wire power_fail_enable,
	input wire system_fail_enable,
	input wire parity_error_enable,
	input wire interruptAck,
	input wire address_strobe_in_n,
	input wire [3:1] ackAddress,
	output reg [2:0] priorityLevel_n,
	output reg autovector_output_n,
	output reg errorVectorAck_n,
	output reg [1:0] errorVector,
	output reg offBoardAck,
	output reg module0_ack_strobe_n,
	output reg module1_ack_strobe_n,
	output reg timer_ack_strobe_n,
	output reg parallel_port_ack_strobe_n,
	output reg serial_port_ack_strobe_n
);
	// ========================================
	// synchronisers
	wire [19:0] rawIn;
	wire [19:0] syncIn;
	// bit 0 is the acknowledge flag, which idles low; every other input idles high
	assign rawIn = {
		backplaneRequest_n,
		powerFailRequest_n,
		systemFailRequest_n,
		boardFail,
		parity_error_request_n,
		mailbox_request_n,
		module0_request_n,
		module1_request_n,
		timer_request_n,
		parallel_port_request_n,
		serial_port_request_n,
		front_panel_nmi_input_n,
		address_strobe_in_n,
		interruptAck
	};

	blm_sync #(.WIDTH(20), .RESET_VALUE(20'hFFFFE)) uSync (
		.clock(clock),
		.rst_n(rst_n),
		.asyncIn(rawIn),
		.syncOut(syncIn)
	);

	wire [7:1] vmeReq;
	wire powerFailLive;
	wire sysFailLive;
	wire boardFailS;
	wire parityLive;
	wire [5:0] mappedLive;
	wire panelIn;
	wire strobeS;
	wire ackS;
	assign vmeReq = ~syncIn[19:13];
	assign powerFailLive = ~syncIn[12];
	assign sysFailLive = ~syncIn[11];
	assign boardFailS = syncIn[10];
	assign parityLive = ~syncIn[9];
	// bit 0 of the mapped set is the mailbox, bit 5 the serial port
	assign mappedLive = ~{syncIn[3], syncIn[4], syncIn[5], syncIn[6], syncIn[7], syncIn[8]};
	assign panelIn = ~syncIn[2];
	assign strobeS = ~syncIn[1];
	assign ackS = syncIn[0];

	wire ackCycle;
	assign ackCycle = ackS & strobeS;

	// ========================================
	// request snapshot, frozen while acknowledging
	// system fail only counts while the board fail qualifier is high
	reg powerFail_ff;
	reg sysFail_ff;
	reg parity_ff;
	reg [5:0] mapped_ff;
	always @(posedge clock) begin
		if (!rst_n) begin
			powerFail_ff <= 1'b0;
			sysFail_ff <= 1'b0;
			parity_ff <= 1'b0;
			mapped_ff <= 6'h00;
		end else if (!ackS) begin
			powerFail_ff <= powerFailLive & power_fail_enable;
			sysFail_ff <= sysFailLive & system_fail_enable & boardFailS;
			parity_ff <= parityLive & parity_error_enable;
			mapped_ff <= mappedLive;
		end
	end

	// ========================================
	// front panel request held until its acknowledge
	reg panel_ff;
	reg autovector_output_ff;
	wire panelAcked;
	assign panelAcked = ackCycle & (ackAddress == `BLM_LVL_NMI) & autovector_output_ff;
	always @(posedge clock) begin
		if (!rst_n) begin
			panel_ff <= 1'b0;
		end else if (panelIn) begin
			panel_ff <= 1'b1;
		end else if (panelAcked) begin
			panel_ff <= 1'b0;
		end
	end

	// ========================================
	// level mapping
	wire [17:0] levelMap;
	assign levelMap = {LEVEL_SERIAL, LEVEL_PARALLEL, LEVEL_TIMER, LEVEL_MODULE1,
		LEVEL_MODULE0, LEVEL_MAILBOX};

	function [2:0] levelOf;
		input [17:0] map;
		input integer idx;
		begin
			levelOf = map[idx*3 +: 3];
		end
	endfunction

	// a level of zero never matches, so such a source stays silent
	function levelMatch;
		input [2:0] addr;
		input [2:0] lvl;
		begin
			levelMatch = (lvl != 3'h0) && (addr == lvl);
		end
	endfunction

	reg [7:1] localLevel;
	reg [2:0] highest;
	integer i;
	integer j;
	wire level7Local;
	assign level7Local = powerFail_ff | sysFail_ff | parity_ff | panel_ff;

	always @* begin
		localLevel = 7'h00;
		highest = 3'h0;
		for (i = 0; i < `BLM_NUM_MAPPED; i = i + 1) begin
			if (mapped_ff[i] && levelOf(levelMap, i) != 3'h0) begin
				localLevel[levelOf(levelMap, i)] = 1'b1;
			end
		end
		localLevel[7] = localLevel[7] | level7Local;
		for (i = 1; i <= 7; i = i + 1) begin
			if (localLevel[i] || vmeReq[i]) begin
				highest = i[2:0];
			end
		end
	end

	// ========================================
	// acknowledge decode
	reg [5:0] nxt_strobe;
	reg nxt_offBoard;
	reg nxt_autoHit;
	wire level7Hit;
	wire anyError;
	wire errorHit;
	assign level7Hit = ackCycle & levelMatch(ackAddress, `BLM_LVL_NMI);
	assign anyError = powerFail_ff | sysFail_ff | parity_ff;
	// a panel autovector already given blocks a second answer in the same cycle
	assign errorHit = level7Hit & ~panel_ff & ~autovector_output_ff & anyError;

	always @* begin
		nxt_strobe = 6'h00;
		nxt_autoHit = level7Hit & panel_ff;
		nxt_offBoard = 1'b0;
		if (ackCycle) begin
			for (j = 0; j < `BLM_NUM_MAPPED; j = j + 1) begin
				if (mapped_ff[j] && levelMatch(ackAddress, levelOf(levelMap, j))) begin
					if (AUTOVECTOR_SELECT[j]) begin
						nxt_autoHit = 1'b1;
					end else begin
						nxt_strobe[j] = 1'b1;
					end
				end
			end
		end
		// backplane cycle only for levels no local source claims
		if (ackCycle && ackAddress != 3'h0) begin
			if (vmeReq[ackAddress] && !localLevel[ackAddress]) begin
				nxt_offBoard = 1'b1;
			end
		end
	end

	// ========================================
	// autovector, held until the strobe negates
	always @(posedge clock) begin
		if (!rst_n) begin
			autovector_output_ff <= 1'b0;
			autovector_output_n <= 1'b1;
		end else if (nxt_autoHit) begin
			autovector_output_ff <= 1'b1;
			autovector_output_n <= 1'b0;
		end else if (!strobeS) begin
			autovector_output_ff <= 1'b0;
			autovector_output_n <= 1'b1;
		end
	end

	// ========================================
	// priority level
	always @(posedge clock) begin
		if (!rst_n) begin
			priorityLevel_n <= 3'h7;
		end else begin
			priorityLevel_n <= ~highest;
		end
	end

	// ========================================
	// error cause bits from the enabled snapshot
	wire [1:0] errCause;
	assign errCause[0] = powerFail_ff | parity_ff;
	assign errCause[1] = powerFail_ff | (sysFail_ff & ~parity_ff);

	// ========================================
	// error vector and its acknowledge
	always @(posedge clock) begin
		if (!rst_n) begin
			errorVectorAck_n <= 1'b1;
			errorVector <= 2'h0;
		end else begin
			errorVectorAck_n <= ~errorHit;
			errorVector <= errCause;
		end
	end

	// ========================================
	// backplane acknowledge
	always @(posedge clock) begin
		if (!rst_n) begin
			offBoardAck <= 1'b0;
		end else begin
			offBoardAck <= nxt_offBoard & ~nxt_autoHit & ~errorHit;
		end
	end

	// ========================================
	// per-source acknowledge strobes
	always @(posedge clock) begin
		if (!rst_n) begin
			module0_ack_strobe_n <= 1'b1;
			module1_ack_strobe_n <= 1'b1;
			timer_ack_strobe_n <= 1'b1;
			parallel_port_ack_strobe_n <= 1'b1;
			serial_port_ack_strobe_n <= 1'b1;
		end else begin
			module0_ack_strobe_n <= ~nxt_strobe[`BLM_SRC_MODULE0];
			module1_ack_strobe_n <= ~nxt_strobe[`BLM_SRC_MODULE1];
			timer_ack_strobe_n <= ~nxt_strobe[`BLM_SRC_TIMER];
			parallel_port_ack_strobe_n <= ~nxt_strobe[`BLM_SRC_PARALLEL];
			serial_port_ack_strobe_n <= ~nxt_strobe[`BLM_SRC_SERIAL];
		end
	end
endmodule // blm_board_interrupt_level_mapper
`default_nettype wire

/* File: src/blm_defs.vh */
`ifndef BLM_DEFS_VH
`define BLM_DEFS_VH
// ========================================
// default level of each mapped local source
`define BLM_LVL_MAILBOX 3'h6
`define BLM_LVL_MODULE0 3'h5
`define BLM_LVL_MODULE1 3'h4
`define BLM_LVL_TIMER 3'h3
`define BLM_LVL_PARALLEL 3'h2
`define BLM_LVL_SERIAL 3'h1
`define BLM_LVL_NMI 3'h7
// ========================================
// default autovector selection per mapped source, bit 0 is mailbox
`define BLM_AUTO_DEFAULT 6'h01
// ========================================
// source indices of the mapped sources
`define BLM_SRC_MAILBOX 0
`define BLM_SRC_MODULE0 1
`define BLM_SRC_MODULE1 2
`define BLM_SRC_TIMER 3
`define BLM_SRC_PARALLEL 4
`define BLM_SRC_SERIAL 5
`define BLM_NUM_MAPPED 6
`endif

/* File: src/blm_sync.v */
`timescale 1ns/100ps
`default_nettype none
// ========================================
// two-stage synchroniser for a bus of levels
module blm_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	input wire clock,
	input wire rst_n,
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1_ff;
	reg [WIDTH-1:0] stage2_ff;

	always @(posedge clock) begin
		if (!rst_n) begin
			stage1_ff <= RESET_VALUE;
			stage2_ff <= RESET_VALUE;
		end else begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign syncOut = stage2_ff;
endmodule // blm_sync
`default_nettype wire

/* File: bench/blm_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ========================================
// port checks of the level mapper
module blm_chk (
	input wire clock,
	input wire rst_n,
	input wire powerFailRequest_n,
	input wire power_fail_enable,
	input wire front_panel_nmi_input_n,
	input wire mailbox_request_n,
	input wire interruptAck,
	input wire address_strobe_in_n,
	input wire [3:1] ackAddress,
	input wire [2:0] priorityLevel_n,
	input wire autovector_output_n,
	input wire [1:0] errorVector,
	input wire offBoardAck,
	input wire module0_ack_strobe_n
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	property p_rst; $rose(rst_n) |-> priorityLevel_n == 3'h7 && autovector_output_n; endproperty
	a_rst: assert property (p_rst) else $error("not idle after reset");
	property p_nmi;
		(!front_panel_nmi_input_n && !interruptAck) [*6] |-> priorityLevel_n == 3'h0;
	endproperty
	a_nmi: assert property (p_nmi) else $error("panel request not level 7");
	property p_pf;
		(!powerFailRequest_n && power_fail_enable && !interruptAck) [*6] |-> errorVector == 2'h3;
	endproperty
	a_pf: assert property (p_pf) else $error("power fail vector wrong");
	property p_sel; !module0_ack_strobe_n |-> $past(interruptAck, 3) && $past(ackAddress, 3) == 3'h5;
	endproperty
	a_sel: assert property (p_sel) else $error("strobe without matching ack");
	property p_hold; !autovector_output_n && !address_strobe_in_n |=> !autovector_output_n; endproperty
	a_hold: assert property (p_hold) else $error("autovector dropped early");
	property p_drop; $rose(address_strobe_in_n) |-> ##[1:5] autovector_output_n; endproperty
	a_drop: assert property (p_drop) else $error("autovector stuck");
	property p_mbx;
		!mailbox_request_n [*4] ##1 (!mailbox_request_n && interruptAck && !address_strobe_in_n
			&& ackAddress == 3'h6) [*6] |-> !autovector_output_n && !offBoardAck;
	endproperty
	a_mbx: assert property (p_mbx) else $error("mailbox not autovectored");
	property p_off; offBoardAck |-> $past(interruptAck, 3) && !$past(address_strobe_in_n, 3);
	endproperty
	a_off: assert property (p_off) else $error("stray backplane ack");
endmodule // blm_chk
bind blm_board_interrupt_level_mapper blm_chk i_chk (.*);
`default_nettype wire

/* File: bench/blm_cpu.sv */
`timescale 1ns/100ps
`default_nettype none
// ========================================
// processor side of the acknowledge cycle
module blm_cpu (
	input wire clock,
	output logic interruptAck,
	output logic address_strobe_in_n,
	output logic [3:1] ackAddress
);
	initial begin
		interruptAck = 1'b0;
		address_strobe_in_n = 1'b1;
		ackAddress = 3'h0;
	end
	task automatic ackStart(input logic [2:0] lvl);
		@(posedge clock) begin
			interruptAck <= 1'b1;
			ackAddress <= lvl;
		end
		@(posedge clock) address_strobe_in_n <= 1'b0;
	endtask
	// strobe negates first; a released address bus shows the inverse level
	task automatic ackEnd;
		@(posedge clock) address_strobe_in_n <= 1'b1;
		@(posedge clock) begin
			interruptAck <= 1'b0;
			ackAddress <= ~ackAddress;
		end
	endtask
endmodule // blm_cpu
`default_nettype wire

/* File: bench/test_board_interrupt_level_mapper.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %0t %h %h", $time, g, e); end end
// ========================================
// scenarios of the level mapper
module test_board_interrupt_level_mapper;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:1] backplaneRequest_n = 7'h7F;
	logic [5:0] locReq_n = 6'h3F;
	logic powerFailRequest_n = 1'b1, systemFailRequest_n = 1'b1, parity_error_request_n = 1'b1;
	logic boardFail = 1'b1, front_panel_nmi_input_n = 1'b1, power_fail_enable = 1'b1;
	logic system_fail_enable = 1'b1, parity_error_enable = 1'b1;
	wire interruptAck, address_strobe_in_n, autovector_output_n, errorVectorAck_n, offBoardAck;
	wire [3:1] ackAddress;
	wire [2:0] priorityLevel_n;
	wire [1:0] errorVector;
	wire [4:0] ackStb_n;
	int n_mismatch = 0, compares = 0, cycles = 0;
	always #10 clock = ~clock;
	blm_cpu i_cpu (.*);
	blm_board_interrupt_level_mapper i_dut (.*, .mailbox_request_n(locReq_n[0]),
		.module0_request_n(locReq_n[1]), .module1_request_n(locReq_n[2]),
		.timer_request_n(locReq_n[3]), .parallel_port_request_n(locReq_n[4]),
		.serial_port_request_n(locReq_n[5]), .module0_ack_strobe_n(ackStb_n[0]),
		.module1_ack_strobe_n(ackStb_n[1]), .timer_ack_strobe_n(ackStb_n[2]),
		.parallel_port_ack_strobe_n(ackStb_n[3]), .serial_port_ack_strobe_n(ackStb_n[4]));
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic t_levels;
		for (int i = 0; i < 6; i++) begin
			@(posedge clock) locReq_n <= ~(6'h01 << i);
			cyc(6);
			`CHK(priorityLevel_n, ~(3'h6 - 3'(i)))
		end
		@(posedge clock) locReq_n <= 6'h3F;
		for (int i = 1; i < 8; i++) begin
			@(posedge clock) backplaneRequest_n <= ~(7'h01 << (i - 1));
			cyc(6);
			`CHK(priorityLevel_n, ~3'(i))
		end
	endtask
	task automatic t_vectored;
		@(posedge clock) begin
			locReq_n <= 6'h3D;
			backplaneRequest_n <= 7'h6F;
		end
		cyc(6);
		i_cpu.ackStart(3'h5);
		// request withdrawn inside the cycle; the frozen copy must still answer
		@(posedge clock) locReq_n <= 6'h3F;
		cyc(6);
		`CHK({ackStb_n, offBoardAck}, 6'h3C)
		i_cpu.ackEnd();
		cyc(6);
		i_cpu.ackStart(3'h5);
		cyc(6);
		`CHK({ackStb_n, offBoardAck}, 6'h3F)
		i_cpu.ackEnd();
		@(posedge clock) backplaneRequest_n <= 7'h7F;
	endtask
	task automatic t_mailbox;
		@(posedge clock) locReq_n <= 6'h3E;
		cyc(6);
		i_cpu.ackStart(3'h6);
		cyc(6);
		`CHK({autovector_output_n, offBoardAck}, 2'b00)
		i_cpu.ackEnd();
		cyc(5);
		`CHK(autovector_output_n, 1'b1)
		@(posedge clock) locReq_n <= 6'h3F;
	endtask
	task automatic t_level7;
		@(posedge clock) begin
			front_panel_nmi_input_n <= 1'b0;
			powerFailRequest_n <= 1'b0;
		end
		cyc(6);
		@(posedge clock) front_panel_nmi_input_n <= 1'b1;
		i_cpu.ackStart(3'h7);
		cyc(4);
		`CHK({autovector_output_n, errorVectorAck_n}, 2'b01)
		i_cpu.ackEnd();
		cyc(6);
		i_cpu.ackStart(3'h7);
		cyc(6);
		`CHK({autovector_output_n, errorVectorAck_n, errorVector}, 4'hB)
		i_cpu.ackEnd();
		@(posedge clock) powerFailRequest_n <= 1'b1;
	endtask
	task automatic t_errvec;
		@(posedge clock) parity_error_request_n <= 1'b0;
		cyc(6);
		`CHK(errorVector, 2'h1)
		@(posedge clock) systemFailRequest_n <= 1'b0;
		cyc(6);
		`CHK(errorVector, 2'h1)
		@(posedge clock) parity_error_enable <= 1'b0;
		cyc(6);
		`CHK(errorVector, 2'h2)
		@(posedge clock) boardFail <= 1'b0;
		cyc(6);
		`CHK(priorityLevel_n, 3'h7)
	endtask
	task automatic stop_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		cyc(16);
		@(posedge clock) rst_n <= 1'b1;
		cyc(4);
		t_levels();
		t_vectored();
		t_mailbox();
		t_level7();
		t_errvec();
		stop_test();
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			stop_test();
		end
	end
endmodule // test_board_interrupt_level_mapper
`default_nettype wire
